// ===== logic/stl_pkg.sv
// Package: constants, register map and carrier types of the translation buffer and cache lookup
package stl_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int TLB_DEPTH = 64;
	localparam int TLB_IDX_W = 6;
	localparam int TAG_W     = 12;
	localparam int SEG_W     = 12;
	localparam int PAGE_W    = 6;
	localparam int OFS_W     = 10;

	// Virtual address layout; printed bit n sits at vector bit 32-n
	localparam int VA_OFS_LSB  = 0;
	localparam int VA_PAGE_LSB = 10;
	localparam int VA_SEG_LSB  = 16;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CMD    = 12'h000;
	localparam logic [11:0] OFS_VADDR  = 12'h004;
	localparam logic [11:0] OFS_DTB    = 12'h008;
	localparam logic [11:0] OFS_PID    = 12'h00C;
	localparam logic [11:0] OFS_TFILL  = 12'h010;
	localparam logic [11:0] OFS_WDATA  = 12'h014;
	localparam logic [11:0] OFS_STATUS = 12'h018;
	localparam logic [11:0] OFS_PHYS   = 12'h01C;
	localparam logic [11:0] OFS_RDATA  = 12'h020;

	// Fill register fields
	localparam int TF_MOD_BIT   = 1;
	localparam int TF_SHR_BIT   = 2;
	localparam int TF_RING1_LSB = 3;
	localparam int TF_RING3_LSB = 6;
	localparam int TF_PHYS_LSB  = 9;

	// Status register fields
	localparam int ST_TLB_HIT   = 0;
	localparam int ST_CACHE_HIT = 1;
	localparam int ST_MISS      = 2;
	localparam int ST_IDX_LSB   = 8;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_TRANSLATE,
		CMD_TLB_FILL,
		CMD_TLB_FLUSH,
		CMD_CACHE_READ,
		CMD_CACHE_FILL,
		CMD_CACHE_INVAL
	} stl_cmd_t;

	// 45-bit entry, printed bit 1 is the most significant
	typedef struct packed {
		logic              valid;
		logic              modified;
		logic              shared;
		logic [2:0]        ring1;
		logic [2:0]        ring3;
		logic [TAG_W-1:0]  process_identifier;
		logic [SEG_W-1:0]  seg_tag;
		logic [TAG_W-1:0]  phys_page;
	} stl_tlb_entry_t;

	typedef struct packed {
		logic [11:0] addr;
		logic        write;
	} stl_ahb_ap_t;

endpackage : stl_pkg

// ===== logic/stl_hash.sv
// Index hash of the translation lookaside buffer
`timescale 1ns/1ps
module stl_hash
	import stl_pkg::*;
(
	input  wire logic [31:0]          descriptor_table_base, // Base register, bit 31 is printed bit 1
	input  wire logic [SEG_W-1:0]     seg,                   // Segment number, MSB is printed bit 1
	input  wire logic [PAGE_W-1:0]    page,                  // Page number, MSB is printed bit 1
	output logic      [TLB_IDX_W-1:0] idx                    // Buffer index, MSB is printed bit 1
);

	// ----------------------------------------------------------------
	// Hash
	// ----------------------------------------------------------------
	// Only ten input bits take part; all else is ignored.
	always_comb
	begin
		idx[5] = page[5] ^ descriptor_table_base[31];
		idx[4] = page[4] ^ descriptor_table_base[30];
		idx[3] = page[3] ^ seg[2];
		idx[2] = page[2] ^ seg[3];
		idx[1] = page[1];
		idx[0] = page[0];
	end

endmodule : stl_hash

// ===== logic/stl_lookup.sv
// Translation buffer and cache lookup engine with an AHB-Lite register slave
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
// Contract
// - Translation buffer holds 64 entries addressed by a six-bit hashed index.
// - Entry is 45 bits: valid, two flags, two rings, process id, segment, physical page.
// - Hash inputs are only base bits 1-2, segment bits 9-10, page bits 1-6.
// - Index bits XOR page with base and segment bits; bits 5-6 pass page through.
// - Wide configuration entry: valid, 12-bit page tag, 32-bit data.
// - Narrow configuration entry: valid, 12-bit page tag, 16-bit data.
// - Entry supplies data only when its valid flag is one.
// - The 12-bit tag names the physical page holding the cached location.
// - Data field holds a copy of the physical location, 16 or 32 bits.
// - 13-bit index configuration uses virtual address bits 20 to 32.
// - 12-bit index configuration uses virtual address bits 21 to 32.
// - Smallest configuration uses virtual address bits 23 to 32 only.
module stl_lookup
	import stl_pkg::*;
#(
	parameter int DATA_W      = 32,
	parameter int CACHE_IDX_W = 13
)(
	input  wire logic              mclk,          // Clock, 100 MHz
	input  wire logic              rst,           // Asynchronous reset, active high
	input  wire logic              hsel,          // Slave select
	input  wire logic [31:0]       haddr,         // Byte address
	input  wire logic [1:0]        htrans,        // Transfer type
	input  wire logic              hwrite,        // Write when high
	input  wire logic [2:0]        hsize,         // Transfer size, word only
	input  wire logic [31:0]       hwdata,        // Write data
	input  wire logic              hready,        // Bus ready
	output logic                   hreadyout,     // Slave ready
	output logic      [31:0]       hrdata,        // Read data
	output logic                   hresp,         // Response, always OKAY
	output logic                   tlb_hit,       // Last translation hit
	output logic                   cache_hit,     // Last cache read hit
	output logic                   mem_read_req,  // Pulse: main memory read on cache miss
	output logic      [21:0]       mem_read_addr  // Physical page and offset of that read
);

	localparam int CDEPTH = 2 ** CACHE_IDX_W;

	// ----------------------------------------------------------------
	// Configuration check
	// ----------------------------------------------------------------
	if (!(DATA_W == 16 || DATA_W == 32))
	begin : g_bad_width
		$error("DATA_W must be 16 or 32");
	end
	if (!(CACHE_IDX_W == 13 || CACHE_IDX_W == 12 || CACHE_IDX_W == 10))
	begin : g_bad_index
		$error("CACHE_IDX_W must be 13, 12 or 10");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	stl_ahb_ap_t           ap_reg;
	logic                  ap_valid_reg;
	logic [31:0]           vaddr_reg;
	logic [31:0]           dtb_reg;
	logic [TAG_W-1:0]      pid_reg;
	logic [31:0]           tfill_reg;
	logic [31:0]           wdata_reg;
	logic [TAG_W-1:0]      ppn_reg;
	stl_cmd_t              cmd_reg;
	logic                  tlb_hit_reg;
	logic                  cache_hit_reg;
	logic                  miss_reg;
	logic [TLB_IDX_W-1:0]  tidx_reg;
	logic [DATA_W-1:0]     cdata_reg;
	logic [21:0]           maddr_reg;
	stl_tlb_entry_t        tlb_mem [TLB_DEPTH];
	logic [TLB_DEPTH-1:0]  tlb_valid_reg;
	logic [TAG_W-1:0]      ctag_mem [CDEPTH];
	logic [DATA_W-1:0]     cdat_mem [CDEPTH];
	logic [CDEPTH-1:0]     cvalid_reg;
	logic                  wr_en;
	logic                  cmd_go;
	stl_cmd_t              cmd;
	logic [SEG_W-1:0]      va_seg;
	logic [PAGE_W-1:0]     va_page;
	logic [TLB_IDX_W-1:0]  t_idx;
	stl_tlb_entry_t        t_ent;
	logic                  t_match;
	logic [CACHE_IDX_W-1:0] c_idx;
	logic                  c_v;
	logic [TAG_W-1:0]      c_t;
	logic                  c_hit;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Zero wait states; every access, mapped or not, answers OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ap_valid_reg <= 1'b0;
			ap_reg       <= '0;
		end
		else if (hready)
		begin
			ap_valid_reg <= hsel && htrans == HTRANS_NONSEQ;
			ap_reg       <= '{addr: haddr[11:0], write: hwrite};
		end
	end

	assign wr_en  = ap_valid_reg && ap_reg.write;
	assign cmd_go = wr_en && ap_reg.addr == OFS_CMD;
	assign cmd    = stl_cmd_t'(hwdata[2:0]);

	always_comb
	begin
		hrdata = RST_WORD;
		if (!ap_valid_reg || ap_reg.write)
			hrdata = RST_WORD;
		else if (ap_reg.addr == OFS_CMD)
			hrdata = {29'h0000_0000, cmd_reg};
		else if (ap_reg.addr == OFS_VADDR)
			hrdata = vaddr_reg;
		else if (ap_reg.addr == OFS_DTB)
			hrdata = dtb_reg;
		else if (ap_reg.addr == OFS_PID)
			hrdata = {20'h0_0000, pid_reg};
		else if (ap_reg.addr == OFS_TFILL)
			hrdata = tfill_reg;
		else if (ap_reg.addr == OFS_WDATA)
			hrdata = wdata_reg;
		else if (ap_reg.addr == OFS_STATUS)
			hrdata = {18'h0_0000, tidx_reg, 5'h00, miss_reg, cache_hit_reg, tlb_hit_reg};
		else if (ap_reg.addr == OFS_PHYS)
			hrdata = {20'h0_0000, ppn_reg};
		else if (ap_reg.addr == OFS_RDATA)
			hrdata = 32'(cdata_reg);
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			vaddr_reg <= RST_WORD;
			dtb_reg   <= RST_WORD;
			pid_reg   <= '0;
			tfill_reg <= RST_WORD;
			wdata_reg <= RST_WORD;
			cmd_reg   <= CMD_NONE;
		end
		else if (wr_en)
		begin
			if (ap_reg.addr == OFS_VADDR)
				vaddr_reg <= hwdata;
			else if (ap_reg.addr == OFS_DTB)
				dtb_reg <= hwdata;
			else if (ap_reg.addr == OFS_PID)
				pid_reg <= hwdata[TAG_W-1:0];
			else if (ap_reg.addr == OFS_TFILL)
				tfill_reg <= hwdata;
			else if (ap_reg.addr == OFS_WDATA)
				wdata_reg <= hwdata;
			else if (ap_reg.addr == OFS_CMD)
				cmd_reg <= cmd;
		end
	end

	// ----------------------------------------------------------------
	// Translation buffer
	// ----------------------------------------------------------------
	assign va_seg  = vaddr_reg[VA_SEG_LSB +: SEG_W];
	assign va_page = vaddr_reg[VA_PAGE_LSB +: PAGE_W];

	stl_hash u_hash (
		.descriptor_table_base (dtb_reg),
		.seg                   (va_seg),
		.page                  (va_page),
		.idx                   (t_idx)
	);

	// Valid bits live apart so that one reset clears all 64 entries
	always_comb
	begin
		t_ent       = tlb_mem[t_idx];
		t_ent.valid = tlb_valid_reg[t_idx];
		t_match     = t_ent.valid && t_ent.seg_tag == va_seg && t_ent.process_identifier == pid_reg;
	end

	always_ff @(posedge mclk)
	begin
		if (cmd_go && cmd == CMD_TLB_FILL)
			tlb_mem[t_idx] <= '{valid: 1'b1,
				modified: tfill_reg[TF_MOD_BIT],
				shared: tfill_reg[TF_SHR_BIT],
				ring1: tfill_reg[TF_RING1_LSB +: 3],
				ring3: tfill_reg[TF_RING3_LSB +: 3],
				process_identifier: pid_reg,
				seg_tag: va_seg,
				phys_page: tfill_reg[TF_PHYS_LSB +: TAG_W]};
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			tlb_valid_reg <= '0;
		else if (cmd_go && cmd == CMD_TLB_FLUSH)
			tlb_valid_reg <= '0;
		else if (cmd_go && cmd == CMD_TLB_FILL)
			tlb_valid_reg[t_idx] <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Cache
	// ----------------------------------------------------------------
	// In the 13- and 12-bit index configurations, low page bits in the index make the cache virtually mapped
	assign c_idx = vaddr_reg[CACHE_IDX_W-1:0];
	assign c_v   = cvalid_reg[c_idx];
	assign c_t   = ctag_mem[c_idx];
	assign c_hit = c_v && c_t == ppn_reg;

	always_ff @(posedge mclk)
	begin
		if (cmd_go && cmd == CMD_CACHE_FILL)
		begin
			ctag_mem[c_idx] <= ppn_reg;
			cdat_mem[c_idx] <= wdata_reg[DATA_W-1:0];
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cvalid_reg <= '0;
		else if (cmd_go && cmd == CMD_CACHE_FILL)
			cvalid_reg[c_idx] <= 1'b1;
		else if (cmd_go && cmd == CMD_CACHE_INVAL)
			cvalid_reg[c_idx] <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Results
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			tlb_hit_reg <= 1'b0;
			tidx_reg    <= '0;
			ppn_reg     <= '0;
		end
		else if (wr_en && ap_reg.addr == OFS_PHYS)
			ppn_reg <= hwdata[TAG_W-1:0];
		else if (cmd_go && cmd == CMD_TRANSLATE)
		begin
			tlb_hit_reg <= t_match;
			tidx_reg    <= t_idx;
			if (t_match)
				ppn_reg <= t_ent.phys_page;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cache_hit_reg <= 1'b0;
			miss_reg      <= 1'b0;
			cdata_reg     <= '0;
			maddr_reg     <= '0;
		end
		else
		begin
			miss_reg <= 1'b0;
			if (cmd_go && cmd == CMD_CACHE_READ)
			begin
				cache_hit_reg <= c_hit;
				miss_reg      <= !c_hit;
				maddr_reg     <= {ppn_reg, vaddr_reg[VA_OFS_LSB +: OFS_W]};
				// A stale or empty entry never hands out its data
				cdata_reg     <= c_hit ? cdat_mem[c_idx] : '0;
			end
		end
	end

	assign tlb_hit       = tlb_hit_reg;
	assign cache_hit     = cache_hit_reg;
	assign mem_read_req  = miss_reg;
	assign mem_read_addr = maddr_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_cmd(stl_cmd_t c);
		cmd_go && cmd == c;
	endsequence

	property p_hash;
		@(posedge mclk) disable iff (rst)
		t_idx == {va_page[5] ^ dtb_reg[31], va_page[4] ^ dtb_reg[30], va_page[3] ^ vaddr_reg[18],
			va_page[2] ^ vaddr_reg[19], va_page[1:0]};
	endproperty
	a_hash: assert property (p_hash) else $error("hash index wrong");

	// One command per data phase, so the next edge still sees the address just filled
	property p_tlb_fill_hit;
		@(posedge mclk) disable iff (rst)
		s_cmd(CMD_TLB_FILL) |=> t_match;
	endproperty
	a_tlb_fill_hit: assert property (p_tlb_fill_hit) else $error("filled entry missed");

	property p_tlb_layout;
		@(posedge mclk) disable iff (rst)
		s_cmd(CMD_TLB_FILL) |=> t_ent.valid && t_ent.phys_page == tfill_reg[TF_PHYS_LSB +: TAG_W]
			&& t_ent.process_identifier == pid_reg && t_ent.seg_tag == va_seg;
	endproperty
	a_tlb_layout: assert property (p_tlb_layout) else $error("entry fields wrong");

	property p_tlb_miss;
		@(posedge mclk) disable iff (rst)
		s_cmd(CMD_TRANSLATE) ##0 (t_ent.process_identifier != pid_reg || !t_ent.valid) |=> !tlb_hit_reg;
	endproperty
	a_tlb_miss: assert property (p_tlb_miss) else $error("hit without match");

	property p_cache_hit;
		@(posedge mclk) disable iff (rst)
		s_cmd(CMD_CACHE_READ) |=> cache_hit_reg == ($past(c_v) && $past(c_t) == $past(ppn_reg))
			&& mem_read_req == !cache_hit_reg;
	endproperty
	a_cache_hit: assert property (p_cache_hit) else $error("cache hit decision wrong");

	property p_fill_read;
		@(posedge mclk) disable iff (rst)
		s_cmd(CMD_CACHE_FILL) |=> c_v && c_t == ppn_reg
			&& cdat_mem[c_idx] == wdata_reg[DATA_W-1:0];
	endproperty
	a_fill_read: assert property (p_fill_read) else $error("filled data lost");

	property p_inval;
		@(posedge mclk) disable iff (rst)
		s_cmd(CMD_CACHE_READ) ##0 !c_v |=> !cache_hit_reg && cdata_reg == '0 && mem_read_req ##1 !mem_read_req;
	endproperty
	a_inval: assert property (p_inval) else $error("invalid entry supplied data");

	property p_miss_addr;
		@(posedge mclk) disable iff (rst)
		s_cmd(CMD_CACHE_READ) |=> mem_read_addr[OFS_W-1:0] == vaddr_reg[OFS_W-1:0]
			&& mem_read_addr[21:OFS_W] == ppn_reg;
	endproperty
	a_miss_addr: assert property (p_miss_addr) else $error("memory address wrong");

endmodule : stl_lookup

// ===== test/stl_mem_model.sv
// Main memory stand-in that records the reads asked for on cache misses
`timescale 1ns/1ps
module stl_mem_model
	import stl_pkg::*;
(
	input  wire logic        mclk,      // Clock
	input  wire logic        rst,       // Reset, active high
	input  wire logic        req,       // Miss read pulse
	input  wire logic [21:0] addr,      // Page and offset
	output logic      [7:0]  reads,     // Reads served
	output logic      [21:0] last_addr  // Address of last read
);
	// A request held two cycles counts twice, so a stretched pulse shows up
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			reads     <= 8'h00;
			last_addr <= 22'h00_0000;
		end
		else if (req)
		begin
			reads     <= reads + 8'h01;
			last_addr <= addr;
		end
	end
endmodule : stl_mem_model

// ===== test/tb_stl_lookup.sv
// Self-checking bench of the translation buffer and cache lookup
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_stl_lookup
	import stl_pkg::*;
;
	logic        mclk, rst, hsel, hwrite, hreadyout, hresp;
	logic        tlb_hit, cache_hit, mem_read_req, cache_hit_n;
	logic [31:0] haddr, hwdata, hrdata, q, va [4], dtb [4], hrdata_n, qn;
	logic [1:0]  htrans;
	logic [21:0] mem_read_addr, last_addr;
	logic [7:0]  reads;
	int          failures, tests_run;

	always #5 mclk = ~mclk;

	stl_lookup u_stl_lookup (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .tlb_hit(tlb_hit), .cache_hit(cache_hit),
		.mem_read_req(mem_read_req), .mem_read_addr(mem_read_addr));

	stl_mem_model u_stl_mem_model (.mclk(mclk), .rst(rst), .req(mem_read_req), .addr(mem_read_addr),
		.reads(reads), .last_addr(last_addr));

	// Narrow data with the smallest index; shares the bus, only its read data and hit flag are watched
	stl_lookup #(.DATA_W(16), .CACHE_IDX_W(10)) u_stl_lookup_narrow (.mclk(mclk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(), .hrdata(hrdata_n), .hresp(), .tlb_hit(), .cache_hit(cache_hit_n), .mem_read_req(),
		.mem_read_addr());

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {20'h0_0000, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : ~d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
		qn = hrdata_n;
		`CHK(hresp, 1'b0)
	endtask : bus

	task automatic cmd(input stl_cmd_t c);
		bus(1'b1, OFS_CMD, {29'h0, c});
		#1;
	endtask : cmd

	function automatic logic [5:0] exp_idx(input logic [31:0] v, input logic [31:0] b);
		return {v[15] ^ b[31], v[14] ^ b[30], v[13] ^ v[18], v[12] ^ v[19], v[11:10]};
	endfunction : exp_idx

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		`CHK({hreadyout, tlb_hit, cache_hit, mem_read_req}, 4'h8)
		bus(1'b0, OFS_STATUS, RST_WORD);
		`CHK(q, RST_WORD)
		bus(1'b0, 12'h0FC, RST_WORD);
		`CHK(q, RST_WORD)
		$display("test_reset done");
	endtask : test_reset

	task automatic test_tlb();
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, OFS_DTB, dtb[i]);
			bus(1'b1, OFS_PID, 32'h0000_0055);
			bus(1'b1, OFS_VADDR, va[i]);
			bus(1'b1, OFS_TFILL, (32'h0000_0100 + i) << TF_PHYS_LSB | 32'h0000_0006);
			cmd(CMD_TLB_FILL);
		end
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, OFS_DTB, dtb[i]);
			bus(1'b1, OFS_VADDR, va[i]);
			cmd(CMD_TRANSLATE);
			`CHK(tlb_hit, 1'b1)
			bus(1'b0, OFS_STATUS, RST_WORD);
			`CHK(q[13:8], exp_idx(va[i], dtb[i]))
			bus(1'b0, OFS_PHYS, RST_WORD);
			`CHK(q[11:0], 12'h100 + 12'(i))
		end
		bus(1'b1, OFS_PID, 32'h0000_0056);
		cmd(CMD_TRANSLATE);
		`CHK(tlb_hit, 1'b0)
		bus(1'b1, OFS_PID, 32'h0000_0055);
		bus(1'b1, OFS_VADDR, va[3] ^ 32'h0800_0000);
		cmd(CMD_TRANSLATE);
		`CHK(tlb_hit, 1'b0)
		bus(1'b0, OFS_STATUS, RST_WORD);
		`CHK(q[13:8], exp_idx(va[3], dtb[3]))
		bus(1'b1, OFS_VADDR, va[3]);
		cmd(CMD_TLB_FLUSH);
		cmd(CMD_TRANSLATE);
		`CHK(tlb_hit, 1'b0)
		$display("test_tlb done");
	endtask : test_tlb

	task automatic rd_cache(input logic [31:0] v, input logic hit, input logic [31:0] d, input logic hit_n,
		input logic [31:0] d_n);
		logic [7:0] n;
		n = reads;
		bus(1'b1, OFS_VADDR, v);
		cmd(CMD_CACHE_READ);
		`CHK(cache_hit, hit)
		`CHK(cache_hit_n, hit_n)
		`CHK(mem_read_req, !hit)
		if (!hit)
			`CHK(mem_read_addr[9:0], v[9:0])
		bus(1'b0, OFS_RDATA, RST_WORD);
		`CHK(q, d)
		`CHK(qn, d_n)
		`CHK(mem_read_req, 1'b0)
		`CHK(reads, n + 8'(!hit))
	endtask : rd_cache

	task automatic test_cache();
		bus(1'b1, OFS_PHYS, 32'h0000_00AB);
		rd_cache(32'h0000_1234, 1'b0, RST_WORD, 1'b0, RST_WORD);
		`CHK(last_addr, {12'h0AB, 10'h234})
		bus(1'b1, OFS_WDATA, 32'hDEAD_BEEF);
		cmd(CMD_CACHE_FILL);
		rd_cache(32'h0000_1234, 1'b1, 32'hDEAD_BEEF, 1'b1, 32'h0000_BEEF);
		rd_cache(32'h0000_3234, 1'b1, 32'hDEAD_BEEF, 1'b1, 32'h0000_BEEF);
		// Bit 12 lies outside the narrow index, so only the wide cache misses here
		rd_cache(32'h0000_0234, 1'b0, RST_WORD, 1'b1, 32'h0000_BEEF);
		bus(1'b1, OFS_PHYS, 32'h0000_00AC);
		rd_cache(32'h0000_1234, 1'b0, RST_WORD, 1'b0, RST_WORD);
		bus(1'b1, OFS_PHYS, 32'h0000_00AB);
		cmd(CMD_CACHE_INVAL);
		rd_cache(32'h0000_1234, 1'b0, RST_WORD, 1'b0, RST_WORD);
		$display("test_cache done");
	endtask : test_cache

	// ----------------------------------------------------------------
	// Verdict
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		// Run is a few hundred cycles; the limit leaves ample margin
		#200_000;
		failures++;
		tally_and_finish();
	end

	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		failures = 0;
		tests_run = 0;
		va = '{32'h0000_0400, 32'h0000_FC00, 32'h000C_2000, 32'h0FF3_0000};
		dtb = '{32'h0000_0000, 32'hC000_0000, 32'h0000_0000, 32'h4000_0000};
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		#1;
		test_reset();
		test_tlb();
		test_cache();
		tally_and_finish();
	end
endmodule : tb_stl_lookup
